// ==== verification/can_engine_model.sv ====
/* Far-side model: protocol engine and other nodes on the bus.
   Assumes the bench calls rx from its own process on the module clock. */
`timescale 1ns/1ps
`default_nettype none
module can_engine_model (
	input  wire logic                    clk_i,      // Module clock.
	input  wire logic                    tx_pin_i,   // Device transmit level.
	input  wire logic                    tx_go_i,    // Pending frame may start.
	input  wire logic                    node_low_i, // Another node drives dominant.
	output logic                         rx_pin_o,   // Wired-and bus level.
	output var can_mode_rx_pkg::eng_in_t eng_o       // Engine report.
);
	int span = 0;
	// The bus stays recessive unless some node pulls it dominant.
	assign rx_pin_o = tx_pin_i & ~node_low_i;
	initial eng_o = '{tx_bit: 1'b1, default: '0};
	// A started frame holds the bus for a fixed span, then reports done.
	always @(posedge clk_i)
	begin
		eng_o.tx_done <= 1'b0;
		if (span > 1)
			span <= span - 1;
		else if (span == 1)
		begin
			span <= 0;
			eng_o.tx_active <= 1'b0;
			eng_o.tx_done <= 1'b1;
		end
		else if (tx_go_i && !eng_o.tx_done)
		begin
			span <= 40;
			eng_o.tx_active <= 1'b1;
		end
	end
	// Presents one assembled frame for a single cycle.
	task automatic rx(input logic ide, input logic [10:0] standard_identifier);
		@(posedge clk_i);
		eng_o.frame <= '{ide: ide, standard_identifier: standard_identifier, extended_identifier: 18'h0, dlc: 4'h2, data: 64'h0};
		eng_o.rx_valid <= 1'b1;
		@(posedge clk_i);
		eng_o.rx_valid <= 1'b0;
	endtask
	// Reports one receive error for a single cycle.
	task automatic err;
		@(posedge clk_i);
		eng_o.rx_error <= 1'b1;
		@(posedge clk_i);
		eng_o.rx_error <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== verification/can_mode_rx_assertions.sv ====
/* Port assertions for can_mode_rx, bound to every instance.
   Assumes the synchronous active-high reset rst_i on clk_i. */
`timescale 1ns/1ps
`default_nettype none
module can_mode_rx_checker (
	input wire logic                     clk_i,       // Module clock.
	input wire logic                     rst_i,       // Synchronous reset.
	input wire logic                     wb_cyc_i,    // Bus cycle.
	input wire logic                     wb_stb_i,    // Bus strobe.
	input wire logic [31:0]              wb_dat_o,    // Read data.
	input wire logic                     wb_ack_o,    // Acknowledge.
	input wire logic                     tx_pin_o,    // Transmit level.
	input wire logic                     tx_pin_oe_o, // Transmit drive.
	input wire logic                     tx_port_o,   // Transmit pin released.
	input wire logic                     rx_port_o,   // Receive pin released.
	input wire can_mode_rx_pkg::eng_in_t eng_i,       // Engine report.
	input wire logic                     rx_bit_o,    // Internal receive line.
	input wire logic                     rx_en_o,     // Receive allowed.
	input wire logic                     passive_o,   // Passive engine.
	input wire logic                     tx_go_o,     // Transmit allowed.
	input wire logic                     irq_o        // Interrupt request.
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bus answers, pin ownership, mode gating and interrupt causes.
	bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside acknowledge");
	tx_release_a: assert property (tx_port_o |-> tx_pin_o && !tx_pin_oe_o)
		else $error("released transmit pin still driven");
	pins_bus_a: assert property (tx_pin_oe_o |-> !tx_port_o && !rx_port_o)
		else $error("driven pin also released");
	rx_release_a: assert property (rx_port_o |-> tx_port_o && !passive_o)
		else $error("receive pin released alone");
	offline_quiet_a: assert property (!rx_en_o |-> rx_bit_o && !tx_go_o && !tx_pin_oe_o)
		else $error("offline mode still active on bus");
	passive_tx_a: assert property (passive_o |-> !tx_go_o)
		else $error("passive mode allows transmit");
	irq_cause_a: assert property ($rose(irq_o) |-> $past(eng_i.rx_valid) ||
		$past(eng_i.rx_valid, 2) || $past(eng_i.rx_error) || $past(wb_cyc_i) || $past(wb_cyc_i, 2))
		else $error("interrupt without a stored frame");
endmodule
bind can_mode_rx can_mode_rx_checker i_can_mode_rx_checker (.*);
`default_nettype wire

// ==== verification/can_mode_rx_tb.sv ====
/* Bench for can_mode_rx: register tasks and test sequences.
   Assumes the design, engine model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module can_mode_rx_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic        low = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack, tx_pin, oe, txp, rxp, rx_pin, rx_bit, rx_en, pas, go, irq;
	logic [6:0]  tbl [4] = '{7'h3A, 7'h26, 7'h79, 7'h42};
	can_mode_rx_pkg::eng_in_t eng;
	int          n_mismatch = 0;
	int          checks_done = 0;
	// Module clock.
	always #5 clk_i = ~clk_i;
	can_mode_rx i_can_mode_rx (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .rx_pin_i(rx_pin), .tx_pin_o(tx_pin), .tx_pin_oe_o(oe),
		.tx_port_o(txp), .rx_port_o(rxp), .eng_i(eng), .rx_bit_o(rx_bit), .rx_en_o(rx_en),
		.passive_o(pas), .tx_go_o(go), .irq_o(irq));
	can_engine_model i_can_engine_model (.clk_i(clk_i), .tx_pin_i(tx_pin), .tx_go_i(go),
		.node_low_i(low), .rx_pin_o(rx_pin), .eng_o(eng));
	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Compares one value.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One classic bus cycle, held until the acknowledge is sampled.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		do
		begin
			@(posedge clk_i);
			i++;
		end
		while (ack !== 1'b1 && i < 20);
		q = rdat;
		cyc <= 1'b0;
		if (ack !== 1'b1)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk("register", q, exp);
	endtask
	// Polls the mode status field until it shows the wanted mode.
	task automatic wm(input logic [2:0] m);
		logic [31:0] q;
		for (int i = 0; i < 100; i++)
		begin
			wb(1'b0, 8'h00, 32'h0, q);
			if (q[7:5] === m)
				break;
		end
		chk("mode", {29'h0, q[7:5]}, {29'h0, m});
	endtask
	// Another node drives eight dominant cycles.
	task automatic dom;
		@(posedge clk_i);
		low <= 1'b1;
		repeat (8) @(posedge clk_i);
		low <= 1'b0;
	endtask
	// Test sequence.
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(8'h00, 32'h480);
		wr(8'h08, 32'h3);
		wr(8'h20, 32'h246);
		wr(8'h40, 32'hFFE);
		wr(8'h28, 32'h1);
		wr(8'h10, 32'h3);
		rc(8'h08, 32'h3);
		wr(8'h00, 32'h0);
		wm(3'h0);
		chk("pins", {28'h0, pas, rxp, txp, oe}, 32'h1);
		wr(8'h08, 32'h63);
		rc(8'h08, 32'h3);
		rc(8'h18, 32'h0);
		$display("Test config done");
		i_can_engine_model.rx(1'b0, 11'h123);
		rc(8'h0C, 32'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		rc(8'h50, 32'h246);
		wr(8'h0C, 32'h1);
		rc(8'h0C, 32'h0);
		i_can_engine_model.rx(1'b1, 11'h123);
		rc(8'h0C, 32'h2);
		wr(8'h0C, 32'h2);
		i_can_engine_model.rx(1'b0, 11'h124);
		rc(8'h0C, 32'h2);
		i_can_engine_model.err();
		rc(8'h1C, 32'h1);
		wr(8'h14, 32'h8);
		chk("go", {31'h0, go}, 32'h0);
		repeat (200) @(posedge clk_i);
		rc(8'h14, 32'h0);
		$display("Test receive done");
		dom();
		wr(8'h14, 32'h8);
		wr(8'h00, 32'h100);
		rc(8'h00, 32'h100);
		wm(3'h1);
		rc(8'h14, 32'h40);
		rc(8'h1C, 32'h1);
		chk("pins", {28'h0, pas, rxp, txp, oe}, 32'h6);
		chk("tx_pin", {31'h0, tx_pin}, 32'h1);
		dom();
		rc(8'h0C, 32'h6);
		$display("Test disable done");
		foreach (tbl[k])
		begin
			wr(8'h00, {21'h0, tbl[k][6:4], 8'h0});
			wm(tbl[k][6:4]);
			chk("pins", {28'h0, pas, rxp, txp, oe}, {28'h0, tbl[k][3:0]});
			chk("rx_en", {31'h0, rx_en}, {31'h0, tbl[k][6:4] != 3'h4});
		end
		rc(8'h1C, 32'h0);
		rc(8'h0C, 32'h6);
		$display("Test modes done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ==== verilog/can_mode_rx.sv ====
/*
 * Mode control, configuration lock, wake detection, error/overload frame
 * signalling and receive filtering into two buffers, with a classic
 * Wishbone slave for the registers. Assumes a protocol engine on the same
 * clock that serialises frames and presents assembled messages.
 */
// The address map and register access over Wishbone were left to the implementer.
// Contract
// - Mode request written in control bits 10:8; entered mode shown in bits 7:5.
// - Mode and status change only after 11 recessive bits of idle bus; the code leaves initialization or disable without waiting.
// - Initialization mode: no transmit or receive, error counter cleared, flags kept.
// - Configuration, timing, enable, filter and mask registers writable only in initialization.
// - Initialization entry waits while a transmission is ongoing.
// - Disable mode: no traffic, flags and counters kept, wake flag still settable.
// - Request 001 enters disable after 11 recessive bits if active; status shows 001.
// - Disable mode releases both bus pins to port function.
// - Configuration bit 14 enables a low-pass filter on the receive line for wake.
// - Disable request during pre-transmit idle wait aborts, sets abort, clears pending.
// - Request 000 is normal mode: pins carry bus, frames sent and received.
// - Listen-only is passive: no error flags or acks, counter idle, transmit pin released.
// - Listen-all (111) ignores errors, accepts all, stores partial frames on error.
// - Loopback ties internal transmit to internal receive; both pins released.
// - Frames assemble separately and move to a receive buffer only when accepted.
// - Receive flag bit 0 or 1 set only on store; software clears it.
// - Enabled receive flag raises the interrupt request.
// - Filters 0,1 with mask 0 feed buffer 0; filters 2-5 with mask 1 feed buffer 1.
// - A bus error emits an error flag field then an error delimiter field.
// - Overload frames sent on request, never more than two in a row.
// - Standard 11-bit and extended 18-bit identifiers are both handled.
// - Data length 0 to 8 bytes; bit rate programmable up to 1 Mbit/s.
// - Mask bit zero makes that identifier bit match regardless of filter.
// - Standard frames match standard filters only; extended frames extended filters only.
`timescale 1ns/1ps
`default_nettype none
module can_mode_rx (
	input  wire logic                   clk_i,        // Module clock, 100 MHz.
	input  wire logic                   rst_i,        // Synchronous reset, active high.
	input  wire logic                   wb_cyc_i,     // Wishbone cycle.
	input  wire logic                   wb_stb_i,     // Wishbone strobe.
	input  wire logic                   wb_we_i,      // Wishbone write enable.
	input  wire logic [7:0]             wb_adr_i,     // Wishbone byte address.
	input  wire logic [3:0]             wb_sel_i,     // Wishbone byte selects.
	input  wire logic [31:0]            wb_dat_i,     // Wishbone write data.
	output logic      [31:0]            wb_dat_o,     // Wishbone read data.
	output logic                        wb_ack_o,     // Wishbone acknowledge.
	input  wire logic                   rx_pin_i,     // Bus receive pin level.
	output logic                        tx_pin_o,     // Bus transmit pin level.
	output logic                        tx_pin_oe_o,  // High while the transmit pin is driven.
	output logic                        tx_port_o,    // Transmit pin handed to port function.
	output logic                        rx_port_o,    // Receive pin handed to port function.
	input  wire can_mode_rx_pkg::eng_in_t eng_i,      // Protocol engine status and data.
	output logic                        rx_bit_o,     // Internal receive line to engine.
	output logic                        rx_en_o,      // Engine may receive.
	output logic                        passive_o,    // Engine sends no acks or error flags.
	output logic                        tx_go_o,      // Engine may start the pending frame.
	output logic                        irq_o         // Receive interrupt request.
);
	// Complete module state.
	typedef struct packed {
		can_mode_rx_pkg::mode_t        mode;
		logic [2:0]                    req;
		logic                          wake_line_filter_enable;
		logic [15:0]                   baud;
		logic [2:0]                    flags;
		logic [1:0]                    inte;
		logic                          transmit_pending_request;
		logic                          transmit_abort_flag;
		logic [5:0][29:0]              filt;
		logic [1:0][29:0]              mask;
		can_mode_rx_pkg::frame_t [1:0] rxb;
		logic [15:0]                   presc;
		logic [3:0]                    idle_cnt;
		can_mode_rx_pkg::sig_t         sig;
		logic [2:0]                    sig_cnt;
		logic [1:0]                    ovld_cnt;
		logic [7:0]                    err_cnt;
		logic [5:0]                    wake_cnt;
		logic                          ack;
		logic [31:0]                   dat;
		logic                          tx_pin;
		logic                          tx_oe;
		logic                          tx_port;
		logic                          rx_port;
		logic                          rx_bit;
		logic                          rx_en;
		logic                          passive;
		logic                          tx_go;
		logic                          irq;
	} state_t;
	state_t                  s_q;
	state_t                  s_d;
	logic   [5:0]            hit;
	logic                    hit0;
	logic                    hit1;
	logic                    tick;
	logic                    bus_idle;
	logic                    active;
	logic                    tx_line;
	logic                    access;
	logic                    wr;
	logic                    cfg_ok;
	logic [31:0]             wmask;
	can_mode_rx_pkg::frame_t fr;
	can_mode_rx_pkg::mode_t  nxt;
	// Acceptance compare per filter; mask bit zero is a match and the
	// identifier format must agree with the filter's format.
	for (genvar i = 0; i < 6; i++)
	begin : g_filt
		logic [29:0] m;
		logic [28:0] diff;
		assign m    = s_q.mask[(i < 2) ? 0 : 1];
		assign diff = ({eng_i.frame.extended_identifier, eng_i.frame.standard_identifier} ^ s_q.filt[i][29:1])
			& (eng_i.frame.ide ? m[29:1] : {18'h00000, m[11:1]});
		assign hit[i] = (s_q.filt[i][0] == eng_i.frame.ide) && (diff == 29'h0);
	end
	assign hit0 = hit[0] | hit[1];
	assign hit1 = |hit[5:2];
	// Shared decode terms.
	assign tick     = (s_q.presc == can_mode_rx_pkg::RST_ZERO16);
	assign bus_idle = (s_q.idle_cnt == can_mode_rx_pkg::IDLE_BITS);
	assign active   = (s_q.mode != can_mode_rx_pkg::MODE_INIT)
		&& (s_q.mode != can_mode_rx_pkg::MODE_DISABLE);
	assign access   = wb_cyc_i && wb_stb_i && !s_q.ack;
	assign wr       = access && wb_we_i;
	assign cfg_ok   = (s_q.mode == can_mode_rx_pkg::MODE_INIT);
	assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	// Internal transmit line: error/overload flags override the engine.
	always_comb
	begin
		if (s_q.sig == can_mode_rx_pkg::SIG_FLAG)
			tx_line = 1'b0;
		else if (s_q.sig == can_mode_rx_pkg::SIG_DELIM)
			tx_line = 1'b1;
		else if (s_q.mode == can_mode_rx_pkg::MODE_NORMAL
			|| s_q.mode == can_mode_rx_pkg::MODE_LOOPBACK)
			tx_line = eng_i.tx_bit;
		else
			tx_line = 1'b1;
	end
	// Next-state logic for the whole block.
	always_comb
	begin
		s_d = s_q;
		fr  = eng_i.frame;
		nxt = can_mode_rx_pkg::mode_t'(s_q.req);
		if (fr.dlc > can_mode_rx_pkg::MAX_DLC)
			fr.dlc = can_mode_rx_pkg::MAX_DLC;
		// Bit-time prescaler and idle-bus counter.
		s_d.presc = tick ? s_q.baud : s_q.presc - 16'h0001;
		if (tick)
		begin
			if (!s_q.rx_bit)
				s_d.idle_cnt = 4'h0;
			else if (!bus_idle)
				s_d.idle_cnt = s_q.idle_cnt + 4'h1;
		end

		// Mode change, only for legal codes and at an acceptable moment.
		if (s_q.req != s_q.mode && (nxt == can_mode_rx_pkg::MODE_NORMAL
			|| nxt == can_mode_rx_pkg::MODE_DISABLE || nxt == can_mode_rx_pkg::MODE_LOOPBACK
			|| nxt == can_mode_rx_pkg::MODE_LISTEN || nxt == can_mode_rx_pkg::MODE_INIT
			|| nxt == can_mode_rx_pkg::MODE_LISTALL))
		begin
			if ((!active || bus_idle)
				&& !(nxt == can_mode_rx_pkg::MODE_INIT && eng_i.tx_active))
				s_d.mode = nxt;
		end
		// Pending transmission: engine completion, then abort by disable.
		if (eng_i.tx_done)
			s_d.transmit_pending_request = 1'b0;
		if (s_q.transmit_pending_request && !eng_i.tx_active && nxt == can_mode_rx_pkg::MODE_DISABLE)
		begin
			s_d.transmit_pending_request = 1'b0;
			s_d.transmit_abort_flag = 1'b1;
		end
		// Error counter: cleared in initialization, idle when passive.
		if (s_q.mode == can_mode_rx_pkg::MODE_INIT)
			s_d.err_cnt = 8'h00;
		else if (eng_i.rx_error && s_q.err_cnt != 8'hFF
			&& (s_q.mode == can_mode_rx_pkg::MODE_NORMAL
			|| s_q.mode == can_mode_rx_pkg::MODE_LOOPBACK))
			s_d.err_cnt = s_q.err_cnt + 8'h01;
		// Error and overload frames, counted in bit times.
		if (eng_i.rx_valid || eng_i.tx_active)
			s_d.ovld_cnt = 2'h0;
		case (s_q.sig)
			can_mode_rx_pkg::SIG_IDLE:
			begin
				if (s_q.mode == can_mode_rx_pkg::MODE_NORMAL
					|| s_q.mode == can_mode_rx_pkg::MODE_LOOPBACK)
				begin
					if (eng_i.bus_error)
					begin
						s_d.sig     = can_mode_rx_pkg::SIG_FLAG;
						s_d.sig_cnt = 3'h0;
					end
					else if (eng_i.overload_req && s_q.ovld_cnt < can_mode_rx_pkg::MAX_OVLD)
					begin
						s_d.sig      = can_mode_rx_pkg::SIG_FLAG;
						s_d.sig_cnt  = 3'h0;
						s_d.ovld_cnt = s_q.ovld_cnt + 2'h1;
					end
				end
			end
			can_mode_rx_pkg::SIG_FLAG:
			begin
				if (tick)
				begin
					s_d.sig_cnt = s_q.sig_cnt + 3'h1;
					if (s_q.sig_cnt == can_mode_rx_pkg::ERR_FLAG_LAST)
					begin
						s_d.sig     = can_mode_rx_pkg::SIG_DELIM;
						s_d.sig_cnt = 3'h0;
					end
				end
			end
			can_mode_rx_pkg::SIG_DELIM:
			begin
				if (tick)
				begin
					s_d.sig_cnt = s_q.sig_cnt + 3'h1;
					if (s_q.sig_cnt == can_mode_rx_pkg::ERR_DELIM_LAST)
						s_d.sig = can_mode_rx_pkg::SIG_IDLE;
				end
			end
			default:
			begin
				s_d.sig = can_mode_rx_pkg::SIG_IDLE;
			end
		endcase
		// Software writes; interrupt flag clears come before hardware sets, the abort flag clear after.
		if (wr)
		begin
			case (wb_adr_i)
				can_mode_rx_pkg::OFS_CTRL:
					if (wb_sel_i[1])
						s_d.req = wb_dat_i[can_mode_rx_pkg::REQ_LSB +: 3];
				can_mode_rx_pkg::OFS_CFG2:
					if (cfg_ok && wb_sel_i[1])
						s_d.wake_line_filter_enable = wb_dat_i[can_mode_rx_pkg::WAKE_LINE_FILTER_ENABLE_BIT];
				can_mode_rx_pkg::OFS_BAUD:
					if (cfg_ok)
						s_d.baud = (s_q.baud & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				can_mode_rx_pkg::OFS_INTF:
					if (wb_sel_i[0])
						s_d.flags = s_q.flags & ~wb_dat_i[2:0];
				can_mode_rx_pkg::OFS_INTE:
					if (cfg_ok && wb_sel_i[0])
						s_d.inte = wb_dat_i[1:0];
				can_mode_rx_pkg::OFS_TXCON:
					if (wb_sel_i[0])
					begin
						s_d.transmit_pending_request = wb_dat_i[can_mode_rx_pkg::TRANSMIT_PENDING_REQUEST_BIT];
						if (wb_dat_i[can_mode_rx_pkg::TRANSMIT_PENDING_REQUEST_BIT])
							s_d.transmit_abort_flag = 1'b0;
					end
				default:
				begin
					for (int i = 0; i < 6; i++)
						if (cfg_ok && wb_adr_i == can_mode_rx_pkg::OFS_FILT0 + 8'(4 * i))
							s_d.filt[i] = (s_q.filt[i] & ~wmask[29:0])
								| (wb_dat_i[29:0] & wmask[29:0]);
					for (int i = 0; i < 2; i++)
						if (cfg_ok && wb_adr_i == can_mode_rx_pkg::OFS_MASK0 + 8'(4 * i))
							s_d.mask[i] = (s_q.mask[i] & ~wmask[29:0])
								| (wb_dat_i[29:0] & wmask[29:0]);
				end
			endcase
		end

		// Wake detection on the raw receive pin while disabled.
		if (s_q.mode == can_mode_rx_pkg::MODE_DISABLE && !rx_pin_i)
		begin
			if (s_q.wake_cnt != can_mode_rx_pkg::WAKE_FILT_CYC)
				s_d.wake_cnt = s_q.wake_cnt + 6'h01;
			if (!s_q.wake_line_filter_enable || s_q.wake_cnt == can_mode_rx_pkg::WAKE_FILT_CYC)
				s_d.flags[can_mode_rx_pkg::WAKE_FLAG] = 1'b1;
		end
		else
			s_d.wake_cnt = 6'h00;
		// Store from the assembly path into a receive buffer.
		if (eng_i.rx_valid && s_q.rx_en)
		begin
			if (s_q.mode == can_mode_rx_pkg::MODE_LISTALL || hit0)
			begin
				s_d.rxb[0]   = fr;
				s_d.flags[0] = 1'b1;
			end
			else if (hit1)
			begin
				s_d.rxb[1]   = fr;
				s_d.flags[1] = 1'b1;
			end
		end
		else if (eng_i.rx_error && s_q.mode == can_mode_rx_pkg::MODE_LISTALL)
		begin
			s_d.rxb[0]   = fr;
			s_d.flags[0] = 1'b1;
		end

		// Registered outputs follow the mode entered.
		s_d.tx_port = !(s_q.mode == can_mode_rx_pkg::MODE_NORMAL
			|| s_q.mode == can_mode_rx_pkg::MODE_LISTALL);
		s_d.rx_port = (s_q.mode == can_mode_rx_pkg::MODE_DISABLE)
			|| (s_q.mode == can_mode_rx_pkg::MODE_LOOPBACK);
		s_d.tx_oe   = !s_d.tx_port;
		s_d.tx_pin  = tx_line | s_d.tx_port;
		case (s_q.mode)
			can_mode_rx_pkg::MODE_LOOPBACK: s_d.rx_bit = tx_line;
			can_mode_rx_pkg::MODE_NORMAL,
			can_mode_rx_pkg::MODE_LISTEN,
			can_mode_rx_pkg::MODE_LISTALL:  s_d.rx_bit = rx_pin_i;
			default:                        s_d.rx_bit = 1'b1;
		endcase
		s_d.rx_en   = active;
		s_d.passive = (s_q.mode == can_mode_rx_pkg::MODE_LISTEN)
			|| (s_q.mode == can_mode_rx_pkg::MODE_LISTALL);
		s_d.tx_go   = s_d.transmit_pending_request && bus_idle && s_q.req == s_q.mode
			&& s_q.sig == can_mode_rx_pkg::SIG_IDLE
			&& (s_q.mode == can_mode_rx_pkg::MODE_NORMAL
			|| s_q.mode == can_mode_rx_pkg::MODE_LOOPBACK);
		s_d.irq     = |(s_d.flags[1:0] & s_q.inte);
		// Wishbone answer: one acknowledge per access, read data alongside.
		s_d.ack = access;
		s_d.dat = 32'h00000000;
		if (access && !wb_we_i)
		begin
			case (wb_adr_i)
				can_mode_rx_pkg::OFS_CTRL:
				begin
					s_d.dat[can_mode_rx_pkg::REQ_LSB +: 3]  = s_q.req;
					s_d.dat[can_mode_rx_pkg::MODE_LSB +: 3] = s_q.mode;
				end
				can_mode_rx_pkg::OFS_CFG2:   s_d.dat[can_mode_rx_pkg::WAKE_LINE_FILTER_ENABLE_BIT] = s_q.wake_line_filter_enable;
				can_mode_rx_pkg::OFS_BAUD:   s_d.dat[15:0] = s_q.baud;
				can_mode_rx_pkg::OFS_INTF:   s_d.dat[2:0] = s_q.flags;
				can_mode_rx_pkg::OFS_INTE:   s_d.dat[1:0] = s_q.inte;
				can_mode_rx_pkg::OFS_ERRCNT: s_d.dat[7:0] = s_q.err_cnt;
				can_mode_rx_pkg::OFS_TXCON:
				begin
					s_d.dat[can_mode_rx_pkg::TRANSMIT_PENDING_REQUEST_BIT] = s_q.transmit_pending_request;
					s_d.dat[can_mode_rx_pkg::TRANSMIT_ABORT_FLAG_BIT] = s_q.transmit_abort_flag;
				end
				default:
				begin
					for (int i = 0; i < 6; i++)
						if (wb_adr_i == can_mode_rx_pkg::OFS_FILT0 + 8'(4 * i))
							s_d.dat[29:0] = s_q.filt[i];
					for (int i = 0; i < 2; i++)
					begin
						if (wb_adr_i == can_mode_rx_pkg::OFS_MASK0 + 8'(4 * i))
							s_d.dat[29:0] = s_q.mask[i];
						if (wb_adr_i == can_mode_rx_pkg::OFS_HIGH_PRIORITY_RX_BUFFER + 8'(16 * i))
							s_d.dat[29:0] = {s_q.rxb[i].extended_identifier, s_q.rxb[i].standard_identifier, s_q.rxb[i].ide};
						if (wb_adr_i == can_mode_rx_pkg::OFS_HIGH_PRIORITY_RX_BUFFER + 8'(16 * i + 4))
							s_d.dat[3:0] = s_q.rxb[i].dlc;
						if (wb_adr_i == can_mode_rx_pkg::OFS_HIGH_PRIORITY_RX_BUFFER + 8'(16 * i + 8))
							s_d.dat = s_q.rxb[i].data[31:0];
						if (wb_adr_i == can_mode_rx_pkg::OFS_HIGH_PRIORITY_RX_BUFFER + 8'(16 * i + 12))
							s_d.dat = s_q.rxb[i].data[63:32];
					end
				end
			endcase
		end
	end

	// State register with synchronous reset into initialization mode.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_q          <= '0;
			s_q.mode     <= can_mode_rx_pkg::MODE_INIT;
			s_q.req      <= can_mode_rx_pkg::MODE_INIT;
			s_q.baud     <= can_mode_rx_pkg::BAUD_RST;
			s_q.presc    <= can_mode_rx_pkg::BAUD_RST;
			s_q.sig      <= can_mode_rx_pkg::SIG_IDLE;
			s_q.tx_pin   <= 1'b1;
			s_q.tx_port  <= 1'b1;
			s_q.rx_bit   <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// Outputs straight from the state register.
	assign wb_dat_o    = s_q.dat;
	assign wb_ack_o    = s_q.ack;
	assign tx_pin_o    = s_q.tx_pin;
	assign tx_pin_oe_o = s_q.tx_oe;
	assign tx_port_o   = s_q.tx_port;
	assign rx_port_o   = s_q.rx_port;
	assign rx_bit_o    = s_q.rx_bit;
	assign rx_en_o     = s_q.rx_en;
	assign passive_o   = s_q.passive;
	assign tx_go_o     = s_q.tx_go;
	assign irq_o       = s_q.irq;
endmodule
`default_nettype wire

// ==== verilog/can_mode_rx_pkg.sv ====
/*
 * Shared constants and carrier types for the mode and receive controller.
 * Assumes a 100 MHz module clock and a protocol engine that presents
 * assembled frames and bit-level transmit data on the module clock.
 */
package can_mode_rx_pkg;
	// Clock and bit timing.
	localparam int CLK_NS          = 10;
	localparam int BIT_TIME_NS     = 1000;
	localparam int BIT_CYC         = BIT_TIME_NS / CLK_NS;
	localparam logic [15:0] BAUD_RST = 16'(BIT_CYC - 1);
	localparam int WAKE_FILT_NS    = 300;
	localparam logic [5:0] WAKE_FILT_CYC = 6'((WAKE_FILT_NS + CLK_NS - 1) / CLK_NS);
	// Bit counts on the bus and frame limits.
	localparam logic [3:0] IDLE_BITS      = 4'hB;
	localparam logic [2:0] ERR_FLAG_LAST  = 3'h5;
	localparam logic [2:0] ERR_DELIM_LAST = 3'h7;
	localparam logic [1:0] MAX_OVLD       = 2'h2;
	localparam logic [3:0] MAX_DLC        = 4'h8;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CFG2   = 8'h04;
	localparam logic [7:0] OFS_BAUD   = 8'h08;
	localparam logic [7:0] OFS_INTF   = 8'h0C;
	localparam logic [7:0] OFS_INTE   = 8'h10;
	localparam logic [7:0] OFS_TXCON  = 8'h14;
	localparam logic [7:0] OFS_ERRCNT = 8'h1C;
	localparam logic [7:0] OFS_FILT0  = 8'h20;
	localparam logic [7:0] OFS_MASK0  = 8'h40;
	localparam logic [7:0] OFS_HIGH_PRIORITY_RX_BUFFER   = 8'h50;
	// Field positions.
	localparam int REQ_LSB     = 8;
	localparam int MODE_LSB    = 5;
	localparam int WAKE_LINE_FILTER_ENABLE_BIT  = 14;
	localparam int TRANSMIT_PENDING_REQUEST_BIT   = 3;
	localparam int TRANSMIT_ABORT_FLAG_BIT   = 6;
	localparam int WAKE_FLAG   = 2;
	// Operating modes, coded as seen in the mode fields.
	typedef enum logic [2:0] {
		MODE_NORMAL   = 3'h0,
		MODE_DISABLE  = 3'h1,
		MODE_LOOPBACK = 3'h2,
		MODE_LISTEN   = 3'h3,
		MODE_INIT     = 3'h4,
		MODE_LISTALL  = 3'h7
	} mode_t;
	// Error and overload frame signalling.
	typedef enum logic [1:0] {
		SIG_IDLE  = 2'h0,
		SIG_FLAG  = 2'h1,
		SIG_DELIM = 2'h3
	} sig_t;
	// One message as held in the assembly and receive buffers.
	typedef struct packed {
		logic        ide;
		logic [10:0] standard_identifier;
		logic [17:0] extended_identifier;
		logic [3:0]  dlc;
		logic [63:0] data;
	} frame_t;
	// What the protocol engine reports each cycle.
	typedef struct packed {
		logic   tx_bit;
		logic   tx_active;
		logic   tx_done;
		logic   rx_valid;
		logic   rx_error;
		logic   bus_error;
		logic   overload_req;
		frame_t frame;
	} eng_in_t;
	localparam logic [15:0] RST_ZERO16 = 16'h0000;
endpackage
